//--- hw/dcffc_pkg.sv
package dcffc_pkg;
	// Register indices; the bus byte address is four times the index.
	localparam logic [9:0] IDX_FREQ_LOW = 10'h03C; // Low frequency threshold.
	localparam logic [9:0] IDX_FREQ_DET = 10'h03D; // Hysteresis and divider threshold.
	localparam logic [9:0] IDX_SSC_CTRL = 10'h03E; // Spread spectrum control.
	localparam logic [9:0] IDX_FIFO_START = 10'h03F; // Output FIFO start level.
	localparam logic [9:0] IDX_FILTER_CTRL = 10'h040; // Sampling filter control.
	localparam logic [9:0] IDX_STATUS = 10'h050; // Block state, read only.

	// Field positions.
	localparam int FREQ_LOW_MSB = 4; // Low threshold field, bits 4:0.
	localparam int HYST_LSB = 6; // Hysteresis field, bits 7:6.
	localparam int DIV_THR_MSB = 5; // Divider threshold field, bits 5:0.
	localparam int SSC_ON_BIT = 4; // Spread spectrum enable.
	localparam int SSC_RATE_BIT = 0; // Spread spectrum rate.
	localparam logic [7:0] SSC_WR_MASK = 8'h3F; // Bits 7:6 are read-only zero.
	localparam int FIL_ALWAYS_BIT = 7; // Adapt at all times.
	localparam int FIL_MEAS_BIT = 6; // Measure without updating.
	localparam int FIL_POLICY_LSB = 4; // Step policy, bits 5:4.
	localparam int FIL_WIN_LSB = 2; // Sample window, bits 3:2.
	localparam int FIL_MODE_BIT = 1; // Wait for equalizer before adapting.
	localparam int FIL_EN_BIT = 0; // Filter adaption enable.

	// Reset values.
	localparam logic [7:0] RST_FREQ_LOW = 8'h14;
	localparam logic [7:0] RST_FREQ_DET = 8'h6F; // Hysteresis 0x1, threshold 0x2F.
	localparam logic [7:0] RST_SSC_CTRL = 8'h00;
	localparam logic [7:0] RST_FIFO_START = 8'h40;
	localparam logic [7:0] RST_FILTER_CTRL = 8'h00;

	// Timing counts.
	localparam int SSC_PERIOD = 3168; // Modulation period in pixel clocks.
	localparam logic [11:0] SSC_LAST = 12'(SSC_PERIOD - 1);
	localparam logic [11:0] SSC_HALF = 12'(SSC_PERIOD / 2 - 1);
	localparam logic [11:0] WIN_BASE = 12'h100; // Smallest sample window, 256 clocks.

	// Output FIFO drain state.
	typedef enum logic [1:0] {
		DRAIN_WAIT = 2'b01,
		DRAIN_RUN = 2'b10
	} dcffc_drain_e;
endpackage : dcffc_pkg

//--- hw/dcffc_hyst_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// Threshold compare with a hysteresis band so the result does not chatter.
module dcffc_hyst_cmp #(
	parameter int FW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [FW-1:0] freq_mhz, // Measured frequency in MHz.
	input wire logic [FW-1:0] threshold_mhz, // Threshold in MHz.
	input wire logic [1:0] hyst_mhz, // Band width in MHz.
	output logic below // High while the frequency is judged below the threshold.
);
	logic below_q; // Current judgement.
	logic below_d; // Next judgement.
	logic [FW:0] upper; // Level that must be reached to leave the low state.

	// Enter below the threshold, leave only at or above threshold plus band.
	always_comb begin
		upper = {1'b0, threshold_mhz} + {{(FW - 1){1'b0}}, hyst_mhz};
		below_d = below_q;
		if (below_q) begin
			if ({1'b0, freq_mhz} >= upper) begin
				below_d = 1'b0; // RULE15
			end
		end else if (freq_mhz < threshold_mhz) begin
			below_d = 1'b1; // RULE15
		end
	end

	// Holds the judgement.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			below_q <= 1'b0;
		end else begin
			below_q <= below_d;
		end
	end

	assign below = below_q;
endmodule : dcffc_hyst_cmp
`default_nettype wire

//--- hw/dcffc_top.sv
// Summary of operation
// RULE1: Divide link clock by 2 below threshold, else 3.
// RULE2: Hysteresis field bits 7:6 counts whole MHz.
// RULE3: Enable bit 4 switches spread spectrum modulation.
// RULE4: Host writes rate first, then enable separately.
// RULE5: Host disables modulation before changing the rate.
// RULE6: Rate 1 modulates at pixel clock over 3168.
// RULE7: Video output waits until FIFO reaches start level.
// RULE8: FIFO holds 256 entries; level counts link clocks.
// RULE9: Always-on bit allows adaption before lock.
// RULE10: Measure-only bit blocks delay updates.
// RULE11: Bits 5:4 select the filter step policy.
// RULE12: Bits 3:2 select a 256 to 2048 window.
// RULE13: Below low threshold the clock is too slow.
// RULE14: Adapt after lock, or after equalizer done; with bit 1 set the code needs both lock and equalizer done.
// RULE15: Hysteresis keeps threshold decisions from chattering.
`timescale 1ns/1ps
`default_nettype none
module dcffc_top #(
	parameter int DATA_W = 12, // Parallel video word width.
	parameter int DEPTH = 256, // Output FIFO entries.
	parameter int AW = 12 // APB address width.
) (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock recovery side.
	input wire logic [7:0] link_freq_mhz, // Measured recovered clock frequency.
	input wire logic link_locked, // Recovered clock is frequency locked.
	input wire logic eq_adapt_done, // Equalizer adaption complete.
	output logic pll_div_three, // High selects divide by 3, low divide by 2.
	output logic link_freq_too_low, // Recovered clock too slow.
	// Spread spectrum generator.
	output logic ssc_active, // Modulation running.
	output logic ssc_sweep_up, // Direction of the triangular sweep.
	// Serial link into the FIFO.
	input wire logic link_valid,
	input wire logic [DATA_W-1:0] link_data,
	output logic link_ready,
	// Parallel video port.
	output logic video_valid,
	output logic [DATA_W-1:0] video_data,
	// Sampling delay filter.
	output logic filter_adapt_active, // Filter may measure.
	output logic filter_update_allowed, // Filter may change its delays.
	output logic [1:0] filter_step_policy, // Step policy code.
	output logic filter_window_done // One-cycle pulse at each window end.
);
	localparam int PW = $clog2(DEPTH); // Pointer width.

	// Register state.
	logic [7:0] freq_low_q, freq_low_d; // Low threshold register.
	logic [7:0] freq_det_q, freq_det_d; // Hysteresis and divider threshold.
	logic [7:0] ssc_q, ssc_d; // Spread spectrum control.
	logic [7:0] fifo_start_q, fifo_start_d; // FIFO start level.
	logic [7:0] filter_q, filter_d; // Filter control.
	logic [31:0] rdata_q, rdata_d; // Read data captured in the setup cycle.

	// Bus decode.
	logic word_ok; // Address is word aligned.
	logic [9:0] idx; // Register index from the address.
	logic mapped; // Address names a register.
	logic wr_en; // Write takes effect this edge.
	logic [31:0] status; // Live block state.

	// Clock divider and low-frequency compare.
	logic below_div; // Frequency under the divider threshold.

	// Spread spectrum counter.
	logic [11:0] ssc_cnt_q, ssc_cnt_d; // Position in the modulation period.
	logic ssc_up_q, ssc_up_d; // Sweep direction.
	logic ssc_run; // Modulation enabled with a valid rate.

	// FIFO state.
	logic [DATA_W-1:0] mem [DEPTH]; // FIFO storage.
	logic [PW-1:0] wptr_q, wptr_d; // Write pointer.
	logic [PW-1:0] rptr_q, rptr_d; // Read pointer.
	logic [PW:0] level_q, level_d; // Entries held.
	dcffc_pkg::dcffc_drain_e drain_q, drain_d; // Drain state.
	logic push; // Word accepted from the link.
	logic pop; // Word sent to the video port.
	logic vvalid_q, vvalid_d; // Video valid flop.
	logic [DATA_W-1:0] vdata_q, vdata_d; // Video data flop.

	// Filter window counter.
	logic [11:0] win_cnt_q, win_cnt_d; // Clocks into the window.
	logic [11:0] win_last; // Last count of the window.
	logic win_done_q, win_done_d; // Window end pulse.

	// Address decode for the bus.
	always_comb begin
		word_ok = (paddr[1:0] == 2'h0);
		idx = 10'(paddr[AW-1:2]);
		mapped = word_ok && (idx == dcffc_pkg::IDX_FREQ_LOW || idx == dcffc_pkg::IDX_FREQ_DET
			|| idx == dcffc_pkg::IDX_SSC_CTRL || idx == dcffc_pkg::IDX_FIFO_START
			|| idx == dcffc_pkg::IDX_FILTER_CTRL || idx == dcffc_pkg::IDX_STATUS);
		wr_en = psel && penable && pwrite && mapped;
	end

	// Zero wait states; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Status word gathers the block's live state.
	always_comb begin
		status = 32'h0000_0000;
		status[0] = pll_div_three;
		status[1] = link_freq_too_low;
		status[2] = (drain_q == dcffc_pkg::DRAIN_RUN);
		status[3] = filter_adapt_active;
		status[4] = ssc_active;
		status[16 +: PW + 1] = level_q;
	end

	// Register writes and read capture.
	always_comb begin
		freq_low_d = freq_low_q;
		freq_det_d = freq_det_q;
		ssc_d = ssc_q;
		fifo_start_d = fifo_start_q;
		filter_d = filter_q;
		rdata_d = rdata_q;
		if (wr_en) begin
			unique case (idx)
				dcffc_pkg::IDX_FREQ_LOW: begin
					freq_low_d = {3'h0, pwdata[dcffc_pkg::FREQ_LOW_MSB:0]}; // RULE13
				end
				dcffc_pkg::IDX_FREQ_DET: begin
					freq_det_d = pwdata[7:0]; // RULE2
				end
				dcffc_pkg::IDX_SSC_CTRL: begin
					ssc_d = pwdata[7:0] & dcffc_pkg::SSC_WR_MASK; // RULE3
				end
				dcffc_pkg::IDX_FIFO_START: begin
					fifo_start_d = pwdata[7:0]; // RULE8
				end
				dcffc_pkg::IDX_FILTER_CTRL: begin
					filter_d = pwdata[7:0];
				end
				default: begin
					// The status word ignores writes.
				end
			endcase
		end
		if (psel && !penable) begin
			// Capture read data in the setup cycle so it comes from a flop.
			if (!word_ok) begin
				rdata_d = 32'h0000_0000;
			end else if (idx == dcffc_pkg::IDX_FREQ_LOW) begin
				rdata_d = {24'h0, freq_low_q};
			end else if (idx == dcffc_pkg::IDX_FREQ_DET) begin
				rdata_d = {24'h0, freq_det_q};
			end else if (idx == dcffc_pkg::IDX_SSC_CTRL) begin
				rdata_d = {24'h0, ssc_q};
			end else if (idx == dcffc_pkg::IDX_FIFO_START) begin
				rdata_d = {24'h0, fifo_start_q};
			end else if (idx == dcffc_pkg::IDX_FILTER_CTRL) begin
				rdata_d = {24'h0, filter_q};
			end else if (idx == dcffc_pkg::IDX_STATUS) begin
				rdata_d = status;
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
	end

	// Register file flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_low_q <= dcffc_pkg::RST_FREQ_LOW;
			freq_det_q <= dcffc_pkg::RST_FREQ_DET;
			ssc_q <= dcffc_pkg::RST_SSC_CTRL;
			fifo_start_q <= dcffc_pkg::RST_FIFO_START;
			filter_q <= dcffc_pkg::RST_FILTER_CTRL;
			rdata_q <= 32'h0000_0000;
		end else begin
			freq_low_q <= freq_low_d;
			freq_det_q <= freq_det_d;
			ssc_q <= ssc_d;
			fifo_start_q <= fifo_start_d;
			filter_q <= filter_d;
			rdata_q <= rdata_d;
		end
	end

	assign prdata = rdata_q;

	// Divider threshold compare with hysteresis in whole MHz.
	dcffc_hyst_cmp #(
		.FW(8)
	) u_div_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.freq_mhz(link_freq_mhz),
		.threshold_mhz({2'h0, freq_det_q[dcffc_pkg::DIV_THR_MSB:0]}),
		.hyst_mhz(freq_det_q[dcffc_pkg::HYST_LSB +: 2]), // RULE2
		.below(below_div)
	);

	// Low-frequency compare with the same hysteresis band.
	dcffc_hyst_cmp #(
		.FW(8)
	) u_low_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.freq_mhz(link_freq_mhz),
		.threshold_mhz(freq_low_q),
		.hyst_mhz(freq_det_q[dcffc_pkg::HYST_LSB +: 2]),
		.below(link_freq_too_low) // RULE13
	);

	// Divide by 2 under the threshold, by 3 otherwise.
	assign pll_div_three = !below_div; // RULE1

	// Spread spectrum runs only when enabled with rate 1; rate 0 is reserved.
	// The host must keep the ordering of rate and enable writes itself.
	always_comb begin
		ssc_run = ssc_q[dcffc_pkg::SSC_ON_BIT] && ssc_q[dcffc_pkg::SSC_RATE_BIT]; // RULE3
		ssc_cnt_d = ssc_cnt_q;
		ssc_up_d = ssc_up_q;
		if (!ssc_run) begin
			ssc_cnt_d = 12'h000;
			ssc_up_d = 1'b1;
		end else if (ssc_cnt_q == dcffc_pkg::SSC_LAST) begin
			ssc_cnt_d = 12'h000; // RULE6
			ssc_up_d = 1'b1;
		end else begin
			ssc_cnt_d = ssc_cnt_q + 12'h001;
			if (ssc_cnt_q == dcffc_pkg::SSC_HALF) begin
				ssc_up_d = 1'b0; // RULE6
			end
		end
	end

	// Spread spectrum flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssc_cnt_q <= 12'h000;
			ssc_up_q <= 1'b1;
		end else begin
			ssc_cnt_q <= ssc_cnt_d;
			ssc_up_q <= ssc_up_d;
		end
	end

	assign ssc_active = ssc_run;
	assign ssc_sweep_up = ssc_up_q;

	// FIFO control; one entry arrives per link clock, so the level counts clocks.
	always_comb begin
		push = link_valid && link_ready;
		pop = (drain_q == dcffc_pkg::DRAIN_RUN) && (level_q != '0); // RULE7
		wptr_d = push ? PW'(wptr_q + 1'b1) : wptr_q;
		rptr_d = pop ? PW'(rptr_q + 1'b1) : rptr_q;
		level_d = level_q;
		if (push && !pop) begin
			level_d = (PW + 1)'(level_q + 1'b1);
		end else if (pop && !push) begin
			level_d = (PW + 1)'(level_q - 1'b1);
		end
		drain_d = drain_q;
		unique case (drain_q)
			dcffc_pkg::DRAIN_WAIT: begin
				// Hold the video port idle until the start level is reached.
				if (level_q != '0 && level_q >= (PW + 1)'(fifo_start_q)) begin
					drain_d = dcffc_pkg::DRAIN_RUN; // RULE7
				end
			end
			dcffc_pkg::DRAIN_RUN: begin
				// Running dry rearms the start level.
				if (level_d == '0) begin
					drain_d = dcffc_pkg::DRAIN_WAIT;
				end
			end
			default: begin
				drain_d = dcffc_pkg::DRAIN_WAIT;
			end
		endcase
		vvalid_d = pop;
		vdata_d = pop ? mem[rptr_q] : vdata_q;
	end

	// Back-pressure toward the link when all entries are held.
	assign link_ready = (level_q != (PW + 1)'(DEPTH)); // RULE8

	// FIFO storage has no reset.
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wptr_q] <= link_data;
		end
	end

	// FIFO pointer and output flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			level_q <= '0;
			drain_q <= dcffc_pkg::DRAIN_WAIT;
			vvalid_q <= 1'b0;
			vdata_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			level_q <= level_d;
			drain_q <= drain_d;
			vvalid_q <= vvalid_d;
			vdata_q <= vdata_d;
		end
	end

	assign video_valid = vvalid_q;
	assign video_data = vdata_q;

	// Filter gating: always-on overrides lock, adapt mode may wait for the equalizer.
	always_comb begin
		filter_adapt_active = filter_q[dcffc_pkg::FIL_EN_BIT]
			&& (filter_q[dcffc_pkg::FIL_ALWAYS_BIT] // RULE9
			|| (link_locked && (!filter_q[dcffc_pkg::FIL_MODE_BIT] || eq_adapt_done))); // RULE14
		filter_update_allowed = filter_adapt_active
			&& !filter_q[dcffc_pkg::FIL_MEAS_BIT]; // RULE10
		filter_step_policy = filter_q[dcffc_pkg::FIL_POLICY_LSB +: 2]; // RULE11
	end

	// Sample window counter, 256 shifted by the window code.
	always_comb begin
		win_last = (dcffc_pkg::WIN_BASE << filter_q[dcffc_pkg::FIL_WIN_LSB +: 2]) - 12'h001; // RULE12
		win_cnt_d = win_cnt_q;
		win_done_d = 1'b0;
		if (!filter_adapt_active) begin
			win_cnt_d = 12'h000;
		end else if (win_cnt_q >= win_last) begin
			win_cnt_d = 12'h000;
			win_done_d = 1'b1; // RULE12
		end else begin
			win_cnt_d = win_cnt_q + 12'h001;
		end
	end

	// Window flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt_q <= 12'h000;
			win_done_q <= 1'b0;
		end else begin
			win_cnt_q <= win_cnt_d;
			win_done_q <= win_done_d;
		end
	end

	assign filter_window_done = win_done_q;
endmodule : dcffc_top
`default_nettype wire

//--- dv/dcffc_link_src.sv
`timescale 1ns/1ps
`default_nettype none
// Serial link source feeding the output FIFO; sends a counting sequence from 0.
module dcffc_link_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go, // Load a new burst.
	input wire logic [8:0] words, // Burst length.
	input wire logic slow, // Idle one cycle after every word.
	input wire logic link_ready,
	output logic link_valid,
	output logic [11:0] link_data,
	output logic busy
);
	logic [8:0] left_q, left_d; // Words still to send.
	logic [11:0] seq_q, seq_d, data_d; // Next word value and next data.
	logic valid_d;
	assign busy = left_q != 9'h000;
	// Offers a word until taken; a released line shows the inverted word.
	always_comb begin
		left_d = left_q;
		seq_d = seq_q;
		valid_d = link_valid;
		data_d = link_data;
		if (go && !busy) begin
			left_d = words;
		end else if (link_valid && link_ready) begin
			left_d = left_q - 9'h001;
			seq_d = seq_q + 12'h001;
			valid_d = !slow && left_q != 9'h001;
			data_d = valid_d ? seq_d : ~link_data;
		end else if (busy && !link_valid) begin
			valid_d = 1'b1;
			data_d = seq_q;
		end
	end
	// Registers the source state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 9'h000;
			seq_q <= 12'h000;
			link_valid <= 1'b0;
			link_data <= 12'h000;
		end else begin
			left_q <= left_d;
			seq_q <= seq_d;
			link_valid <= valid_d;
			link_data <= data_d;
		end
	end
endmodule : dcffc_link_src
`default_nettype wire

//--- dv/dcffc_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the control block.
module dcffc_props #(
	parameter int DEPTH = 256
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] link_freq_mhz,
	input wire logic pll_div_three,
	input wire logic link_freq_too_low,
	input wire logic ssc_active,
	input wire logic link_valid,
	input wire logic link_ready,
	input wire logic video_valid,
	input wire logic filter_adapt_active,
	input wire logic filter_update_allowed,
	input wire logic [1:0] filter_step_policy,
	input wire logic filter_window_done
);
	logic [9:0] held_q, held_d; // Words taken in and not yet shown; never below the level.
	// Up on each push, down on each video word.
	always_comb held_d = held_q + 10'(link_valid && link_ready) - 10'(video_valid);
	// Registers the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) held_q <= 10'h000;
		else held_q <= held_d;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_div_steady: assert property (
		($stable(link_freq_mhz) && !psel) [*4] |-> $stable(pll_div_three))
		else $error("divider select moved with steady inputs");
	chk_low_steady: assert property (
		($stable(link_freq_mhz) && !psel) [*4] |-> $stable(link_freq_too_low))
		else $error("too-low flag moved with steady inputs");
	chk_ssc_by_write: assert property (
		$changed(ssc_active) |-> $past(psel) && $past(penable) && $past(pwrite))
		else $error("modulation changed without a write");
	chk_policy_by_write: assert property (
		$changed(filter_step_policy) |-> $past(psel) && $past(penable) && $past(pwrite))
		else $error("step policy changed without a write");
	chk_update_needs_adapt: assert property (
		filter_update_allowed |-> filter_adapt_active)
		else $error("delay update without adaption");
	chk_window_gap: assert property (
		filter_window_done |=> (!filter_window_done) [*8])
		else $error("window ends too close together");
	chk_video_after_push: assert property (
		video_valid |-> held_q != 10'h000)
		else $error("video word with nothing taken in");
	chk_full_refuse: assert property (
		!link_ready |-> held_q >= 10'(DEPTH))
		else $error("input refused before the FIFO is full");
endmodule : dcffc_props
bind dcffc_top dcffc_props #(.DEPTH(DEPTH)) dcffc_props_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .link_freq_mhz, .pll_div_three, .link_freq_too_low, .ssc_active, .link_valid,
	.link_ready, .video_valid, .filter_adapt_active, .filter_update_allowed,
	.filter_step_policy, .filter_window_done);
`default_nettype wire

//--- dv/dcffc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for registers, frequency compare, spread spectrum, FIFO start and filter.
module dcffc_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, e_q, pll_div_three, link_freq_too_low, ssc_active, ssc_sweep_up;
	logic [11:0] paddr = 12'h000, link_data, video_data, v_exp = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [7:0] link_freq_mhz = 8'h40;
	logic link_locked = 1'b0, eq_adapt_done = 1'b0, go = 1'b0, slow = 1'b0, busy;
	logic link_valid, link_ready, video_valid, filter_window_done;
	logic filter_adapt_active, filter_update_allowed;
	logic [1:0] filter_step_policy;
	logic [8:0] words = 9'h000;
	int n_mismatch = 0, num_checks = 0, v_n = 0, tick = 0;
	int n_full = 0; // Cycles in which the FIFO refused a word.
	always #12.5 pclk = ~pclk; // 40 MHz.
	dcffc_top dcffc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link_freq_mhz, .link_locked, .eq_adapt_done,
		.pll_div_three, .link_freq_too_low, .ssc_active, .ssc_sweep_up, .link_valid,
		.link_data, .link_ready, .video_valid, .video_data, .filter_adapt_active,
		.filter_update_allowed, .filter_step_policy, .filter_window_done);
	dcffc_link_src dcffc_link_src_i (.pclk, .presetn, .go, .words, .slow, .link_ready,
		.link_valid, .link_data, .busy);
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// One APB transfer by register index; held until pready, then one idle cycle.
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [9:0] i, input logic [31:0] x, input logic e);
		apb(1'b0, i, 8'h00);
		chk("prdata", q, x);
		chk("pslverr", {31'h0, e_q}, {31'h0, e});
	endtask : rd
	// Video words must come out in order.
	always @(posedge pclk) begin
		if (video_valid === 1'b1) begin
			chk("video_data", {20'h0, video_data}, {20'h0, v_exp});
			v_exp <= v_exp + 12'h001;
			v_n++;
		end
		if (link_ready === 1'b0) n_full++;
		tick++;
		if (tick == 60000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic t_regs;
		rd(dcffc_pkg::IDX_FREQ_DET, {24'h0, 2'h1, 6'h2F}, 1'b0);
		rd(dcffc_pkg::IDX_FREQ_LOW, 32'h14, 1'b0);
		rd(dcffc_pkg::IDX_SSC_CTRL, 32'h0, 1'b0);
		rd(dcffc_pkg::IDX_FIFO_START, 32'h40, 1'b0);
		rd(dcffc_pkg::IDX_FILTER_CTRL, 32'h0, 1'b0);
		rd(10'h080, 32'h0, 1'b1);
		apb(1'b1, dcffc_pkg::IDX_FREQ_LOW, 8'hF5);
		rd(dcffc_pkg::IDX_FREQ_LOW, 32'h15, 1'b0);
		apb(1'b1, dcffc_pkg::IDX_FREQ_LOW, 8'h14);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'hEE);
		rd(dcffc_pkg::IDX_SSC_CTRL, 32'h2E, 1'b0);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h00);
	endtask : t_regs
	task automatic fq(input logic [7:0] v, input logic dv, input logic lo);
		link_freq_mhz <= v;
		cyc(4);
		chk("div3", {31'h0, pll_div_three}, {31'h0, dv});
		chk("too_low", {31'h0, link_freq_too_low}, {31'h0, lo});
	endtask : fq
	task automatic t_freq;
		fq(8'h2E, 1'b0, 1'b0);
		fq(8'h2F, 1'b0, 1'b0);
		fq(8'h30, 1'b1, 1'b0);
		fq(8'h13, 1'b0, 1'b1);
		fq(8'h14, 1'b0, 1'b1);
		fq(8'h15, 1'b0, 1'b0);
		apb(1'b1, dcffc_pkg::IDX_FREQ_DET, 8'hEF);
		fq(8'h31, 1'b0, 1'b0);
		fq(8'h32, 1'b1, 1'b0);
	endtask : t_freq
	task automatic t_ssc;
		int n;
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h01);
		chk("ssc", {31'h0, ssc_active}, 32'h0);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h11);
		chk("ssc", {31'h0, ssc_active}, 32'h1);
		n = 0;
		while (ssc_sweep_up !== 1'b0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (ssc_sweep_up === 1'b0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		chk("sweep_low", n, dcffc_pkg::SSC_PERIOD / 2);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h01);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h00);
		apb(1'b1, dcffc_pkg::IDX_SSC_CTRL, 8'h10);
		chk("ssc", {31'h0, ssc_active}, 32'h0);
	endtask : t_ssc
	task automatic push(input logic [8:0] n, input logic s);
		words <= n;
		slow <= s;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		cyc(2);
		while (busy === 1'b1) @(posedge pclk);
		cyc(20);
	endtask : push
	task automatic t_fifo;
		apb(1'b1, dcffc_pkg::IDX_FIFO_START, 8'h04);
		push(9'h003, 1'b1);
		chk("words_out", v_n, 32'h0);
		rd(dcffc_pkg::IDX_STATUS, 32'h0003_0001, 1'b0);
		push(9'h001, 1'b0);
		chk("words_out", v_n, 32'h4);
		push(9'h008, 1'b0);
		chk("words_out", v_n, 32'hC);
	endtask : t_fifo
	// Start level 255 with a long burst: the FIFO fills once and refuses one word.
	task automatic t_full;
		apb(1'b1, dcffc_pkg::IDX_FIFO_START, 8'hFF);
		push(9'h110, 1'b0);
		cyc(280);
		chk("words_out", v_n, 32'h11C);
		chk("refused_cycles", n_full, 32'h1);
	endtask : t_full
	task automatic fil(input logic [7:0] c, input logic lk, input logic eq, input logic [1:0] x);
		apb(1'b1, dcffc_pkg::IDX_FILTER_CTRL, c);
		link_locked <= lk;
		eq_adapt_done <= eq;
		cyc(2);
		chk("adapt_update", {30'h0, filter_adapt_active, filter_update_allowed}, {30'h0, x});
	endtask : fil
	task automatic t_filter;
		int n;
		fil(8'h01, 1'b0, 1'b0, 2'h0);
		fil(8'h01, 1'b1, 1'b0, 2'h3);
		fil(8'h41, 1'b1, 1'b0, 2'h2);
		fil(8'h03, 1'b1, 1'b0, 2'h0);
		fil(8'h03, 1'b1, 1'b1, 2'h3);
		fil(8'hC1, 1'b0, 1'b0, 2'h2);
		fil(8'h81, 1'b0, 1'b0, 2'h3);
		for (int p = 0; p < 4; p++) begin
			fil(8'(p << 4) | 8'h81, 1'b1, 1'b0, 2'h3);
			chk("policy", {30'h0, filter_step_policy}, p);
		end
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, dcffc_pkg::IDX_FILTER_CTRL, 8'(c << 2) | 8'h81);
			while (filter_window_done !== 1'b1) @(posedge pclk);
			n = 1;
			@(posedge pclk);
			while (filter_window_done !== 1'b1) begin
				@(posedge pclk);
				n++;
			end
			chk("window", n, 256 << c);
		end
	endtask : t_filter
	initial begin
		cyc(6);
		presetn <= 1'b1;
		cyc(2);
		t_regs();
		t_freq();
		t_ssc();
		t_fifo();
		t_full();
		t_filter();
		wrap_up();
	end
endmodule : dcffc_top_tb
`default_nettype wire
